// file: rtl/pfc_cfg.svh
// Constants of the frequency-change control block and its host sequencer
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_DATA_W 24
`define PFC_ADDR_W 8
`define PFC_RESET_VAL 24'h00_0000

// Device register indices on the link
`define PFC_REG_INT 8'h03
`define PFC_REG_FRAC 8'h04
`define PFC_REG_MODE 8'h06
`define PFC_REG_CP 8'h09
`define PFC_REG_CALCFG 8'h0a
`define PFC_REG_BAND 8'h15
`define PFC_REG_OUTDIV 8'h16
`define PFC_REG_OUTCFG 8'h17

// Field positions
`define PFC_FRAC_MODE_BIT 11
`define PFC_AUTOMATIC_VCO_CALIBRATION_OFF_BIT 11
`define PFC_BAND_MSB 8
`define PFC_BAND_LSB 1
`define PFC_DIV_MSB 5
`define PFC_DIV_LSB 0
`define PFC_GAIN_MSB 10
`define PFC_GAIN_LSB 6
`define PFC_AUTOMUTE_BIT 7
`define PFC_BUF_MSB 5
`define PFC_BUF_LSB 4
`define PFC_CPDN_MSB 6
`define PFC_CPDN_LSB 0
`define PFC_CPUP_MSB 13
`define PFC_CPUP_LSB 7
`define PFC_OFFMAG_MSB 20
`define PFC_OFFMAG_LSB 14
`define PFC_OFFUP_BIT 21
`define PFC_OFFDN_BIT 22

// Calibration time
`define PFC_CLK_MHZ 200
`define PFC_CAL_TIME_NS 8640
`define PFC_CAL_CYCLES ((`PFC_CAL_TIME_NS * `PFC_CLK_MHZ) / 1000)

// Host sequencer registers, Avalon byte addresses
`define PFC_HOST_AW 5
`define PFC_H_INT 5'h00
`define PFC_H_FRAC 5'h04
`define PFC_H_BAND 5'h08
`define PFC_H_CP 5'h0c
`define PFC_H_CTRL 5'h10
`define PFC_H_STATUS 5'h14
`define PFC_CTRL_GO 0
`define PFC_CTRL_FRAC 1
`define PFC_CTRL_MANUAL 2
`define PFC_CTRL_PDHIGH 3
`define PFC_CTRL_INTCHG 4
`define PFC_CTRL_W 4

`endif

// file: rtl/pfc_host_ctrl.sv
// Host sequencer: runs one frequency change over the register link
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_host_ctrl
	import pfc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [`PFC_HOST_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	pfc_link_if.host link
);

	// ctrl keeps CTRL bits 4:1, so each flag sits one below its bus bit
	localparam int C_FRAC = `PFC_CTRL_FRAC - 1;
	localparam int C_MANUAL = `PFC_CTRL_MANUAL - 1;
	localparam int C_PDHIGH = `PFC_CTRL_PDHIGH - 1;
	localparam int C_INTCHG = `PFC_CTRL_INTCHG - 1;

	pfc_host_s st_reg;
	pfc_host_s st_next;

	logic busy;
	logic goReq;
	logic fracM;
	logic [6:0] gainQuarter;
	logic [6:0] offMag;
	logic [`PFC_DATA_W-1:0] cpBase;

	assign busy = (st_reg.state != PFC_H_IDLE);
	assign goReq = avs_write && (avs_address == `PFC_H_CTRL) &&
		avs_writedata[`PFC_CTRL_GO];
	// A new change waits until the running one has finished
	assign avs_waitrequest = goReq && busy;
	assign fracM = st_reg.ctrl[C_FRAC];

	always_comb begin
		gainQuarter = {2'b00, st_reg.cmdCp[`PFC_CPUP_MSB:`PFC_CPUP_LSB+2]};
		offMag = st_reg.cmdCp[`PFC_OFFMAG_MSB:`PFC_OFFMAG_LSB];
		if (!fracM) begin
			offMag = 7'h00;
		end else if (offMag > gainQuarter) begin
			offMag = gainQuarter;
		end
		cpBase = {3'b000, offMag,
			st_reg.cmdCp[`PFC_CPUP_MSB:`PFC_CPDN_LSB]};
	end

	always_comb begin
		st_next = st_reg;
		link.wrEn = 1'b0;
		link.rdEn = 1'b0;
		link.addr = '0;
		link.wdata = '0;

		if (avs_write && !avs_waitrequest) begin
			unique case (avs_address)
				`PFC_H_INT: st_next.cmdInt = avs_writedata[`PFC_DATA_W-1:0];
				`PFC_H_FRAC: st_next.cmdFrac = avs_writedata[`PFC_DATA_W-1:0];
				`PFC_H_BAND: st_next.cmdBand = avs_writedata[7:0];
				`PFC_H_CP: st_next.cmdCp = avs_writedata[`PFC_DATA_W-1:0];
				`PFC_H_CTRL: begin
					st_next.ctrl = avs_writedata[`PFC_CTRL_W:1];
				end
				default: begin
				end
			endcase
		end

		unique case (st_reg.state)
			PFC_H_IDLE: begin
				if (goReq) begin
					st_next.state = PFC_H_MODE;
				end
			end
			PFC_H_MODE: begin
				link.wrEn = 1'b1;
				link.addr = `PFC_REG_MODE;
				link.wdata[`PFC_FRAC_MODE_BIT] = fracM;
				st_next.state = PFC_H_CAL;
			end
			PFC_H_CAL: begin
				link.wrEn = 1'b1;
				link.addr = `PFC_REG_CALCFG;
				link.wdata[`PFC_AUTOMATIC_VCO_CALIBRATION_OFF_BIT] = st_reg.ctrl[C_MANUAL];
				st_next.state = PFC_H_CPPRE;
			end
			PFC_H_CPPRE: begin
				link.wrEn = 1'b1;
				link.addr = `PFC_REG_CP;
				link.wdata = cpBase;
				link.wdata[`PFC_OFFUP_BIT] = fracM &&
					!st_reg.ctrl[C_PDHIGH];
				st_next.state = st_reg.ctrl[C_MANUAL] ?
					PFC_H_BAND : PFC_H_INT;
			end
			PFC_H_BAND: begin
				link.wrEn = 1'b1;
				link.addr = `PFC_REG_BAND;
				link.wdata[`PFC_BAND_MSB:`PFC_BAND_LSB] = st_reg.cmdBand;
				st_next.state = PFC_H_INT;
			end
			PFC_H_INT: begin
				link.wrEn = !fracM || st_reg.ctrl[C_INTCHG];
				link.addr = `PFC_REG_INT;
				link.wdata = st_reg.cmdInt;
				st_next.state = fracM ? PFC_H_FRAC : PFC_H_SETTLE;
			end
			PFC_H_FRAC: begin
				link.wrEn = 1'b1;
				link.addr = `PFC_REG_FRAC;
				link.wdata = st_reg.cmdFrac;
				st_next.state = PFC_H_SETTLE;
			end
			PFC_H_SETTLE: begin
				// Only calibration end is seen; loop settling is not observed
				if (!link.calBusy) begin
					st_next.state = PFC_H_CPPOST;
				end
			end
			PFC_H_CPPOST: begin
				link.wrEn = fracM && st_reg.ctrl[C_PDHIGH];
				link.addr = `PFC_REG_CP;
				link.wdata = cpBase;
				link.wdata[`PFC_OFFUP_BIT] = 1'b1;
				st_next.state = PFC_H_READ;
			end
			PFC_H_READ: begin
				link.rdEn = 1'b1;
				link.addr = `PFC_REG_BAND;
				st_next.state = PFC_H_RDWAIT;
			end
			PFC_H_RDWAIT: begin
				st_next.readBand = link.rdata[`PFC_BAND_MSB:`PFC_BAND_LSB];
				st_next.state = PFC_H_IDLE;
			end
			default: begin
				st_next.state = PFC_H_IDLE;
			end
		endcase
	end

	always_comb begin
		avs_readdata = 32'h0000_0000;
		if (avs_read) begin
			unique case (avs_address)
				`PFC_H_INT: avs_readdata[`PFC_DATA_W-1:0] = st_reg.cmdInt;
				`PFC_H_FRAC: avs_readdata[`PFC_DATA_W-1:0] = st_reg.cmdFrac;
				`PFC_H_BAND: avs_readdata[7:0] = st_reg.cmdBand;
				`PFC_H_CP: avs_readdata[`PFC_DATA_W-1:0] = st_reg.cmdCp;
				`PFC_H_CTRL: avs_readdata[`PFC_CTRL_W:1] = st_reg.ctrl;
				`PFC_H_STATUS: avs_readdata[8:0] = {st_reg.readBand, busy};
				default: avs_readdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule // pfc_host_ctrl
`default_nettype wire

// file: rtl/pfc_link_if.sv
// Register link between the host sequencer and the synthesizer control
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
interface pfc_link_if;
	logic wrEn;
	logic rdEn;
	logic [`PFC_ADDR_W-1:0] addr;
	logic [`PFC_DATA_W-1:0] wdata;
	logic [`PFC_DATA_W-1:0] rdata;
	logic calBusy;

	modport dev (
		input wrEn,
		input rdEn,
		input addr,
		input wdata,
		output rdata,
		output calBusy
	);

	modport host (
		output wrEn,
		output rdEn,
		output addr,
		output wdata,
		input rdata,
		input calBusy
	);
endinterface
`default_nettype wire

// file: rtl/pfc_pkg.sv
// Types shared by both ends of the frequency-change link
`include "pfc_cfg.svh"
package pfc_pkg;

	typedef enum logic [1:0] {
		PFC_D_IDLE = 2'h0,
		PFC_D_CAL = 2'h1
	} pfc_dev_state_e;

	typedef struct packed {
		pfc_dev_state_e state;
		logic [`PFC_DATA_W-1:0] intReg;
		logic [`PFC_DATA_W-1:0] fracReg;
		logic [`PFC_DATA_W-1:0] modeReg;
		logic [`PFC_DATA_W-1:0] cpReg;
		logic [`PFC_DATA_W-1:0] calCfgReg;
		logic [`PFC_DATA_W-1:0] bandReg;
		logic [`PFC_DATA_W-1:0] outDivReg;
		logic [`PFC_DATA_W-1:0] outCfgReg;
		logic [`PFC_DATA_W-1:0] appInt;
		logic [`PFC_DATA_W-1:0] appFrac;
		logic [15:0] calCnt;
		logic [`PFC_DATA_W-1:0] rdata;
	} pfc_dev_s;

	typedef enum logic [3:0] {
		PFC_H_IDLE = 4'h0,
		PFC_H_MODE = 4'h1,
		PFC_H_CAL = 4'h3,
		PFC_H_CPPRE = 4'h2,
		PFC_H_BAND = 4'h6,
		PFC_H_INT = 4'h7,
		PFC_H_FRAC = 4'h5,
		PFC_H_SETTLE = 4'h4,
		PFC_H_CPPOST = 4'hc,
		PFC_H_READ = 4'hd,
		PFC_H_RDWAIT = 4'hf
	} pfc_host_state_e;

	typedef struct packed {
		pfc_host_state_e state;
		logic [`PFC_DATA_W-1:0] cmdInt;
		logic [`PFC_DATA_W-1:0] cmdFrac;
		logic [7:0] cmdBand;
		logic [`PFC_DATA_W-1:0] cmdCp;
		logic [`PFC_CTRL_W-1:0] ctrl;
		logic [7:0] readBand;
	} pfc_host_s;

endpackage

// file: rtl/pfc_synth_dev.sv
// Synthesizer frequency-change control: registers, calibration and mute
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_synth_dev
	import pfc_pkg::*;
#(
	parameter int CAL_CYCLES = `PFC_CAL_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	pfc_link_if.dev link,
	input wire logic [7:0] calBand,
	output logic calBusy,
	output logic fracMode,
	output logic [`PFC_DATA_W-1:0] prescalerInt,
	output logic [`PFC_DATA_W-1:0] dsmFrac,
	output logic [7:0] vcoBand,
	output logic outMute,
	output logic [1:0] bufEnable,
	output logic [5:0] outDivider,
	output logic [4:0] outGain,
	output logic [6:0] cpUpGain,
	output logic [6:0] cpDnGain,
	output logic [6:0] cpOffMag,
	output logic cpOffUpEn,
	output logic cpOffDnEn
);

	localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

	pfc_dev_s st_reg;
	pfc_dev_s st_next;

	logic autoCalOn;
	logic fracSel;
	logic calStart;

	always_comb begin
		st_next = st_reg;
		autoCalOn = !st_reg.calCfgReg[`PFC_AUTOMATIC_VCO_CALIBRATION_OFF_BIT];
		fracSel = st_reg.modeReg[`PFC_FRAC_MODE_BIT];
		calStart = 1'b0;

		// Calibration runs to its end; the measurement itself is outside
		if (st_reg.state == PFC_D_CAL) begin
			st_next.calCnt = st_reg.calCnt + 16'h0001;
		end

		unique case (st_reg.state)
			PFC_D_IDLE: begin
			end
			PFC_D_CAL: begin
				if (st_reg.calCnt == CAL_LAST) begin
					st_next.state = PFC_D_IDLE;
					st_next.bandReg[`PFC_BAND_MSB:`PFC_BAND_LSB] = calBand;
					st_next.appInt = st_reg.intReg;
					st_next.appFrac = st_reg.fracReg;
				end
			end
		endcase

		if (link.wrEn) begin
			unique case (link.addr)
				`PFC_REG_INT: begin
					st_next.intReg = link.wdata;
					if (!autoCalOn) begin
						st_next.appInt = link.wdata;
					end else if (!fracSel) begin
						calStart = 1'b1;
					end
				end
				`PFC_REG_FRAC: begin
					st_next.fracReg = link.wdata;
					if (!autoCalOn) begin
						st_next.appFrac = link.wdata;
					end else if (fracSel) begin
						calStart = 1'b1;
					end
				end
				`PFC_REG_MODE: begin
					st_next.modeReg = link.wdata;
				end
				`PFC_REG_CP: begin
					st_next.cpReg = link.wdata;
				end
				`PFC_REG_CALCFG: begin
					st_next.calCfgReg = link.wdata;
				end
				`PFC_REG_BAND: begin
					// With automatic_vco_calibration on, a later calibration overwrites the band
					st_next.bandReg = link.wdata;
				end
				`PFC_REG_OUTDIV: begin
					st_next.outDivReg = link.wdata;
				end
				`PFC_REG_OUTCFG: begin
					st_next.outCfgReg = link.wdata;
				end
				default: begin
				end
			endcase
		end

		// A new trigger restarts any calibration in flight
		if (calStart) begin
			st_next.state = PFC_D_CAL;
			st_next.calCnt = 16'h0000;
		end

		if (link.rdEn) begin
			unique case (link.addr)
				`PFC_REG_INT: st_next.rdata = st_reg.intReg;
				`PFC_REG_FRAC: st_next.rdata = st_reg.fracReg;
				`PFC_REG_MODE: st_next.rdata = st_reg.modeReg;
				`PFC_REG_CP: st_next.rdata = st_reg.cpReg;
				`PFC_REG_CALCFG: st_next.rdata = st_reg.calCfgReg;
				`PFC_REG_BAND: st_next.rdata = st_reg.bandReg;
				`PFC_REG_OUTDIV: st_next.rdata = st_reg.outDivReg;
				`PFC_REG_OUTCFG: st_next.rdata = st_reg.outCfgReg;
				default: st_next.rdata = `PFC_RESET_VAL;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.rdata = st_reg.rdata;
	assign link.calBusy = calBusy;
	assign calBusy = (st_reg.state == PFC_D_CAL);
	assign fracMode = st_reg.modeReg[`PFC_FRAC_MODE_BIT];
	assign prescalerInt = st_reg.appInt;
	assign dsmFrac = st_reg.appFrac;
	// Band steers the VCO straight from the register
	assign vcoBand = st_reg.bandReg[`PFC_BAND_MSB:`PFC_BAND_LSB];
	assign outDivider = st_reg.outDivReg[`PFC_DIV_MSB:`PFC_DIV_LSB];
	assign outGain = st_reg.outDivReg[`PFC_GAIN_MSB:`PFC_GAIN_LSB];
	// Mute covers the whole calibration and drops on the same edge that loads the new band
	assign outMute = (outDivider == 6'h00) ||
		(st_reg.outCfgReg[`PFC_AUTOMUTE_BIT] && calBusy);
	// Buffers are independent of mute
	assign bufEnable = st_reg.outCfgReg[`PFC_BUF_MSB:`PFC_BUF_LSB];
	assign cpUpGain = st_reg.cpReg[`PFC_CPUP_MSB:`PFC_CPUP_LSB];
	assign cpDnGain = st_reg.cpReg[`PFC_CPDN_MSB:`PFC_CPDN_LSB];
	assign cpOffMag = st_reg.cpReg[`PFC_OFFMAG_MSB:`PFC_OFFMAG_LSB];
	assign cpOffUpEn = st_reg.cpReg[`PFC_OFFUP_BIT];
	assign cpOffDnEn = st_reg.cpReg[`PFC_OFFDN_BIT];

endmodule // pfc_synth_dev
`default_nettype wire

// file: verification/pfc_link_sva.sv
// Assertions on the register link between host sequencer and device
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_link_sva #(
	parameter int CAL_CYCLES = `PFC_CAL_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [`PFC_ADDR_W-1:0] addr,
	input wire logic [`PFC_DATA_W-1:0] wdata,
	input wire logic [`PFC_DATA_W-1:0] rdata,
	input wire logic calBusy
);
	logic fracM, autoOff, bandNew, fw, cp;
	logic [15:0] calCnt;
	assign fw = wrEn && (fracM ? addr == `PFC_REG_FRAC : addr == `PFC_REG_INT);
	assign cp = wrEn && addr == `PFC_REG_CP;
	// Mode copies follow the link writes, so no device internals are needed
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			fracM <= 1'b0;
			autoOff <= 1'b0;
			bandNew <= 1'b0;
			calCnt <= 16'h0000;
		end else begin
			if (wrEn && addr == `PFC_REG_MODE)
				fracM <= wdata[`PFC_FRAC_MODE_BIT];
			if (wrEn && addr == `PFC_REG_CALCFG)
				autoOff <= wdata[`PFC_AUTOMATIC_VCO_CALIBRATION_OFF_BIT];
			if (wrEn && addr == `PFC_REG_BAND)
				bandNew <= 1'b1;
			else if (fw)
				bandNew <= 1'b0;
			// Restarts on each trigger, as a retrigger restarts the count
			calCnt <= (fw && !autoOff) ? 16'h0000 :
				(calBusy ? calCnt + 16'h0001 : 16'h0000);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_frac_cal_start: assert property (fw && fracM && !autoOff |=> calBusy)
		else $error("fraction write did not start calibration");
	a_int_cal_start: assert property (fw && !fracM && !autoOff |=> calBusy)
		else $error("integer write did not start calibration");
	a_manual_no_cal: assert property (fw && autoOff && !calBusy |=> !calBusy)
		else $error("calibration ran with automatic_vco_calibration off");
	a_cal_bounded: assert property (calBusy |-> calCnt < 16'(CAL_CYCLES))
		else $error("calibration too long");
	a_cal_full_len: assert property ($fell(calBusy) |-> calCnt == 16'(CAL_CYCLES))
		else $error("calibration too short");
	a_band_first: assert property (fw && autoOff |-> bandNew)
		else $error("frequency word before band write");
	a_int_no_offset: assert property (cp && !fracM |-> wdata[22:14] == 9'h000)
		else $error("offset left on in integer mode");
	a_frac_no_down: assert property (cp && fracM |-> !wdata[22])
		else $error("down offset enabled");
	a_offset_quarter: assert property (cp |-> wdata[20:14] <= wdata[13:7] >> 2)
		else $error("offset above quarter of gain");
	a_rdata_holds: assert property (!rdEn |=> $stable(rdata))
		else $error("read data changed without read");
	c_cal_done: cover property ($fell(calBusy));
	c_manual_hop: cover property (fw && autoOff);
	c_band_read: cover property (rdEn && addr == `PFC_REG_BAND);
endmodule // pfc_link_sva
`default_nettype wire

// file: verification/pll_frequency_change_control_tb.sv
// Self-checking bench: host sequencer and device joined, plus a lone device
`timescale 1ns/1ps
`default_nettype none
`include "pfc_cfg.svh"
module pll_frequency_change_control_tb;
	localparam int CALN = 8;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] avAddr = 5'h00;
	logic avRd = 1'b0;
	logic avWr = 1'b0;
	logic [31:0] avWd = 32'h0000_0000;
	logic [31:0] avRdData, rd;
	logic avWait, busy, fracMode, mute, upEn, dnEn, busy2, mute2, busyQ;
	logic [7:0] calBand = 8'h5a;
	logic [23:0] pInt, dFrac, int2;
	logic [7:0] band, band2;
	logic [6:0] upG, dnG, offMag;
	logic [5:0] div2;
	logic [4:0] gain2;
	logic [1:0] buf2;
	int bad_count = 0;
	int check_count = 0;
	int intWr = 0;
	int calRuns = 0;
	int r0;
	pfc_link_if link_i ();
	pfc_link_if link2_i ();
	pfc_host_ctrl pfc_host_ctrl_i (.sys_clk(sys_clk), .resetn(resetn),
		.avs_address(avAddr), .avs_read(avRd), .avs_write(avWr),
		.avs_writedata(avWd), .avs_readdata(avRdData),
		.avs_waitrequest(avWait), .link(link_i.host));
	pfc_synth_dev #(.CAL_CYCLES(CALN)) pfc_synth_dev_i (.sys_clk(sys_clk),
		.resetn(resetn), .link(link_i.dev), .calBand(calBand), .calBusy(busy),
		.fracMode(fracMode), .prescalerInt(pInt), .dsmFrac(dFrac),
		.vcoBand(band), .outMute(mute), .bufEnable(), .outDivider(),
		.outGain(), .cpUpGain(upG), .cpDnGain(dnG), .cpOffMag(offMag),
		.cpOffUpEn(upEn), .cpOffDnEn(dnEn));
	pfc_synth_dev #(.CAL_CYCLES(CALN)) pfc_synth_dev_solo_i (.sys_clk(sys_clk),
		.resetn(resetn), .link(link2_i.dev), .calBand(calBand),
		.calBusy(busy2), .fracMode(), .prescalerInt(int2), .dsmFrac(),
		.vcoBand(band2), .outMute(mute2), .bufEnable(buf2),
		.outDivider(div2), .outGain(gain2), .cpUpGain(), .cpDnGain(),
		.cpOffMag(), .cpOffUpEn(), .cpOffDnEn());
	pfc_link_sva #(.CAL_CYCLES(CALN)) pfc_link_sva_i (.sys_clk(sys_clk),
		.resetn(resetn), .wrEn(link_i.wrEn), .rdEn(link_i.rdEn),
		.addr(link_i.addr), .wdata(link_i.wdata), .rdata(link_i.rdata),
		.calBusy(link_i.calBusy));
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		busyQ <= link_i.calBusy;
		if (link_i.calBusy && !busyQ)
			calRuns++;
		if (link_i.wrEn && link_i.addr == `PFC_REG_INT)
			intWr++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avAddr <= a;
		avWd <= d;
		avWr <= w;
		avRd <= !w;
		// Only the watchdog ends a wait that never sees waitrequest low
		do begin
			@(posedge sys_clk);
		end while (avWait !== 1'b0);
		rd = avRdData;
		avWr <= 1'b0;
		avRd <= 1'b0;
	endtask
	task automatic idle_wait();
		do begin
			av(1'b0, `PFC_H_STATUS, 32'h0000_0000);
		end while (rd[0] !== 1'b0);
	endtask
	task automatic busy_wait();
		while (busy !== 1'b1) begin
			@(posedge sys_clk);
		end
	endtask
	// Direct access to the lone device; data inverted once released
	task automatic lx(input logic w, input logic [7:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		link2_i.wrEn <= w;
		link2_i.rdEn <= !w;
		link2_i.addr <= a;
		link2_i.wdata <= d;
		@(posedge sys_clk);
		link2_i.wrEn <= 1'b0;
		link2_i.rdEn <= 1'b0;
		link2_i.wdata <= ~d;
		#1;
		rd = {8'h00, link2_i.rdata};
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		link2_i.wrEn = 1'b0;
		link2_i.rdEn = 1'b0;
		link2_i.addr = 8'h00;
		link2_i.wdata = 24'h00_0000;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		av(1'b1, `PFC_H_INT, 32'h0000_0064);
		av(1'b1, `PFC_H_FRAC, 32'h0012_3456);
		av(1'b1, `PFC_H_CP, 32'h0005_1428);
		av(1'b1, `PFC_H_CTRL, 32'h0000_0013);
		busy_wait();
		chk(dFrac, 32'h0000_0000);
		idle_wait();
		chk(dFrac, 32'h0012_3456);
		chk(pInt, 32'h0000_0064);
		chk(fracMode, 32'h0000_0001);
		chk(band, 32'h0000_005a);
		chk(rd[8:1], 32'h0000_005a);
		chk({dnEn, upEn, offMag}, 32'h0000_008a);
		chk({upG, dnG}, 32'h0000_1428);
		chk(mute, 32'h0000_0001);
		$display("done frac auto");
		calBand <= 8'h66;
		r0 = intWr;
		av(1'b1, `PFC_H_FRAC, 32'h0000_0100);
		av(1'b1, `PFC_H_CTRL, 32'h0000_0003);
		av(1'b1, `PFC_H_CTRL, 32'h0000_0003);
		idle_wait();
		chk(intWr, r0);
		chk(dFrac, 32'h0000_0100);
		chk(band, 32'h0000_0066);
		$display("done small step");
		r0 = calRuns;
		av(1'b1, `PFC_H_CTRL, 32'h0000_0003);
		idle_wait();
		chk(calRuns, r0 + 1);
		av(1'b1, `PFC_H_INT, 32'h0000_00c8);
		av(1'b1, `PFC_H_CTRL, 32'h0000_0001);
		busy_wait();
		chk(pInt, 32'h0000_0064);
		idle_wait();
		chk(pInt, 32'h0000_00c8);
		chk(fracMode, 32'h0000_0000);
		chk({dnEn, upEn, offMag}, 32'h0000_0000);
		$display("done int auto");
		r0 = calRuns;
		av(1'b1, `PFC_H_BAND, 32'h0000_0033);
		av(1'b1, `PFC_H_FRAC, 32'h000a_bcde);
		av(1'b1, `PFC_H_CTRL, 32'h0000_0007);
		idle_wait();
		chk(band, 32'h0000_0033);
		chk(dFrac, 32'h000a_bcde);
		av(1'b1, `PFC_H_INT, 32'h0000_012c);
		av(1'b1, `PFC_H_BAND, 32'h0000_0044);
		av(1'b1, `PFC_H_CTRL, 32'h0000_0005);
		idle_wait();
		chk(pInt, 32'h0000_012c);
		chk(band, 32'h0000_0044);
		chk(calRuns, r0);
		av(1'b0, 5'h1c, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("done manual");
		av(1'b1, `PFC_H_CTRL, 32'h0000_000b);
		busy_wait();
		chk(upEn, 32'h0000_0000);
		idle_wait();
		chk(upEn, 32'h0000_0001);
		av(1'b0, `PFC_H_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_000a);
		$display("done fast detector");
		lx(1'b1, `PFC_REG_OUTDIV, 24'h00_056a);
		chk({gain2, div2}, 32'h0000_056a);
		chk(mute2, 32'h0000_0000);
		lx(1'b1, `PFC_REG_OUTDIV, 24'h00_0540);
		chk(mute2, 32'h0000_0001);
		lx(1'b1, `PFC_REG_OUTDIV, 24'h00_0001);
		lx(1'b1, `PFC_REG_OUTCFG, 24'h00_00a0);
		chk({buf2, mute2}, 32'h0000_0004);
		lx(1'b1, `PFC_REG_INT, 24'h00_0050);
		chk({busy2, mute2, int2}, 32'h0300_0000);
		for (int n = 0; n < 50 && busy2 === 1'b1; n++) begin
			chk(mute2, 32'h0000_0001);
			@(posedge sys_clk);
			#1;
		end
		chk({band2, int2}, 32'h6600_0050);
		chk(mute2, 32'h0000_0000);
		lx(1'b0, `PFC_REG_BAND, 24'h00_0000);
		chk(rd[8:1], 32'h0000_0066);
		lx(1'b0, 8'h20, 24'h00_0000);
		chk(rd, 32'h0000_0000);
		lx(1'b1, `PFC_REG_CALCFG, 24'h00_0800);
		lx(1'b1, `PFC_REG_BAND, 24'h00_0044);
		chk(band2, 32'h0000_0022);
		lx(1'b1, `PFC_REG_INT, 24'h00_0060);
		chk({busy2, int2}, 32'h0000_0060);
		$display("done lone device");
		tally_and_finish();
	end
endmodule // pll_frequency_change_control_tb
`default_nettype wire
